// >>> design/fbcs_connect_sync.sv
// Connect and start-synchronous command handling with phase tracking
// What this block does
// - Sync select bit: 0 async, 1 sync
// - Transfer codes 00/11 single, 01 continuous
// - Top mode bit enables subcommands
// - Async connect waits for start-sync before phase 3
// - Sync connect goes phase 1 to 3
// - Start-sync code 0DH, echoed, phase 2 only
// - Valid start-sync moves phase 2 to 3
// - Sync error mask completes start-sync at once
// - Start-sync under local tool raises warning 1
// - Connect 0EH sets mode and opens link
// - Unconnected: only connect, disconnect, no-op accepted
//
// The address-and-strobe port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module fbcs_connect_sync #(
	// Command codes not fixed by this block's own behaviour
	parameter logic [7:0] CMD_DISCONNECT = 8'h0F,
	parameter logic [7:0] CMD_NOP = 8'h00
) (
	// Clock and reset
	input wire logic clock_i,
	input wire logic arst_n_i,
	// Received command
	input wire logic cmd_valid_i,
	input wire logic [7:0] cmd_code_i,
	input wire logic [7:0] connection_mode_byte_i,
	input wire logic [7:0] cycle_multiplier_i,
	// Link events
	input wire logic sync_edge_i,
	input wire logic link_error_i,
	input wire logic local_tool_i,
	// Response
	output logic rsp_valid_o,
	output logic [7:0] rsp_code_o,
	// Link state
	output logic [2:0] phase_o,
	output logic sync_select_bit_o,
	output logic continuous_o,
	output logic subcommand_enable_bit_o,
	// Register port
	input wire logic [7:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [31:0] reg_rdata_o,
	// Interrupt
	output logic irq_o
);
	////////////////////////////////////////////////////////////////////////////////
	// Reset release
	logic rst_meta;
	logic rst_n;

	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Local tool pin synchroniser
	logic local_meta;
	logic local_sync;

	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			local_meta <= 1'b0;
			local_sync <= 1'b0;
		end else begin
			local_meta <= local_tool_i;
			local_sync <= local_meta;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Command decode
	fbcs_pkg::fbcs_phase_e phase;
	fbcs_pkg::fbcs_phase_e next_phase;
	logic sync_pending;
	logic [31:0] ctrl;
	logic sync_error_mask_setting;
	logic is_connect;
	logic is_disconnect;
	logic is_nop;
	logic is_sync_set;
	logic mult_ok;
	logic connect_ok;
	logic reject;
	logic warn1;
	logic data_warn;
	logic sync_now;
	logic mode_sync;
	logic mode_rsvd_bad;
	logic [7:0] cycle_multiplier;

	assign sync_error_mask_setting = ctrl[fbcs_pkg::CTRL_SYNC_MASK_BIT];
	assign is_connect = cmd_valid_i && (cmd_code_i == fbcs_pkg::CMD_CONNECT);
	assign is_disconnect = cmd_valid_i && (cmd_code_i == CMD_DISCONNECT);
	assign is_nop = cmd_valid_i && (cmd_code_i == CMD_NOP);
	assign is_sync_set = cmd_valid_i && (cmd_code_i == fbcs_pkg::CMD_SYNC_SET);
	assign mult_ok = (cycle_multiplier_i >= fbcs_pkg::MULT_MIN) && (cycle_multiplier_i <= fbcs_pkg::MULT_MAX);
	// Out-of-range multiplier: warning, command ignored
	assign connect_ok = is_connect && (phase == fbcs_pkg::PHASE1) && mult_ok;
	assign data_warn = is_connect && (phase == fbcs_pkg::PHASE1) && !mult_ok;
	// Unconnected: anything but connect, disconnect and no-op is refused
	assign reject = cmd_valid_i && (phase == fbcs_pkg::PHASE1)
		&& !is_connect && !is_disconnect && !is_nop;
	// Start-sync in phase 1, or in phase 2 while the local tool runs
	assign warn1 = is_sync_set && ((phase == fbcs_pkg::PHASE1)
		|| ((phase == fbcs_pkg::PHASE2) && local_sync));
	// Start-sync completes now when masked, else at the next sync edge
	assign sync_now = (phase == fbcs_pkg::PHASE2) && !local_sync
		&& ((is_sync_set && sync_error_mask_setting)
		|| ((is_sync_set || sync_pending) && sync_edge_i));

	////////////////////////////////////////////////////////////////////////////////
	// Mode byte decoder
	fbcs_mode_decode u_mode (
		.clock_i(clock_i),
		.rst_n_i(rst_n),
		.load_i(connect_ok),
		.connection_mode_byte_i(connection_mode_byte_i),
		.sync_select_bit_o(mode_sync),
		.continuous_o(continuous_o),
		.subcommand_enable_bit_o(subcommand_enable_bit_o),
		.reserved_bad_o(mode_rsvd_bad)
	);

	assign sync_select_bit_o = mode_sync;

	////////////////////////////////////////////////////////////////////////////////
	// Phase machine
	always_comb begin
		next_phase = phase;
		case (phase)
			fbcs_pkg::PHASE1: begin
				if (connect_ok) begin
					// Sync connect skips phase 2
					if (connection_mode_byte_i[fbcs_pkg::MODE_SYNC_BIT]) begin
						next_phase = fbcs_pkg::PHASE3;
					end else begin
						next_phase = fbcs_pkg::PHASE2;
					end
				end
			end
			fbcs_pkg::PHASE2: begin
				if (is_disconnect) begin
					next_phase = fbcs_pkg::PHASE1;
				end else if (sync_now) begin
					next_phase = fbcs_pkg::PHASE3;
				end
			end
			fbcs_pkg::PHASE3: begin
				if (is_disconnect) begin
					next_phase = fbcs_pkg::PHASE1;
				end else if (link_error_i) begin
					// Stays out of phase 3 until start-sync is resent
					next_phase = fbcs_pkg::PHASE2;
				end
			end
			default: begin
				next_phase = fbcs_pkg::PHASE1;
			end
		endcase
	end

	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			phase <= fbcs_pkg::PHASE1;
		end else begin
			phase <= next_phase;
		end
	end

	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			sync_pending <= 1'b0;
		end else if ((next_phase != fbcs_pkg::PHASE2) || sync_now) begin
			sync_pending <= 1'b0;
		end else if (is_sync_set && !local_sync) begin
			sync_pending <= 1'b1;
		end
	end

	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			cycle_multiplier <= fbcs_pkg::BYTE_ZERO;
		end else if (connect_ok) begin
			cycle_multiplier <= cycle_multiplier_i;
		end
	end

	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			phase_o <= fbcs_pkg::PHASE1;
		end else begin
			phase_o <= next_phase;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Response
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			rsp_valid_o <= 1'b0;
			rsp_code_o <= fbcs_pkg::BYTE_ZERO;
		end else begin
			rsp_valid_o <= cmd_valid_i;
			if (cmd_valid_i) begin
				// Echo, or no-op for a command refused when unconnected
				rsp_code_o <= reject ? CMD_NOP : cmd_code_i;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Events and registers
	logic [fbcs_pkg::EV_W-1:0] ev_raw;
	logic [fbcs_pkg::EV_W-1:0] irq_stat;
	logic [fbcs_pkg::EV_W-1:0] irq_mask;
	logic wr_ctrl;
	logic wr_stat;
	logic wr_mask;

	assign ev_raw[fbcs_pkg::EV_WARN1] = warn1;
	assign ev_raw[fbcs_pkg::EV_PHASE3] = (next_phase == fbcs_pkg::PHASE3) && (phase != fbcs_pkg::PHASE3);
	assign ev_raw[fbcs_pkg::EV_REJECT] = reject;
	assign ev_raw[fbcs_pkg::EV_LINK_ERR] = link_error_i && (phase == fbcs_pkg::PHASE3) && !is_disconnect;
	assign ev_raw[fbcs_pkg::EV_DATA_WARN] = data_warn;
	assign wr_ctrl = reg_wr_i && (reg_addr_i == fbcs_pkg::REG_CTRL);
	assign wr_stat = reg_wr_i && (reg_addr_i == fbcs_pkg::REG_IRQ_STAT);
	assign wr_mask = reg_wr_i && (reg_addr_i == fbcs_pkg::REG_IRQ_MASK);

	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			ctrl <= fbcs_pkg::CTRL_RESET;
		end else if (wr_ctrl) begin
			ctrl <= fbcs_pkg::CTRL_RESET;
			ctrl[fbcs_pkg::CTRL_SYNC_MASK_BIT] <= reg_wdata_i[fbcs_pkg::CTRL_SYNC_MASK_BIT];
		end
	end

	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			irq_mask <= fbcs_pkg::EV_RESET;
		end else if (wr_mask) begin
			irq_mask <= reg_wdata_i[fbcs_pkg::EV_W-1:0];
		end
	end

	// Set beats write-one-to-clear in the same cycle
	genvar gi;
	generate
		for (gi = 0; gi < fbcs_pkg::EV_W; gi++) begin : g_ev
			always_ff @(posedge clock_i or negedge rst_n) begin
				if (!rst_n) begin
					irq_stat[gi] <= 1'b0;
				end else if (ev_raw[gi]) begin
					irq_stat[gi] <= 1'b1;
				end else if (wr_stat && reg_wdata_i[gi]) begin
					irq_stat[gi] <= 1'b0;
				end
			end
		end
	endgenerate

	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |(irq_stat & irq_mask);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Register read
	logic [31:0] next_rdata;

	always_comb begin
		next_rdata = fbcs_pkg::WORD_ZERO;
		case (reg_addr_i)
			fbcs_pkg::REG_CTRL: begin
				next_rdata = ctrl;
			end
			fbcs_pkg::REG_STATUS: begin
				next_rdata[fbcs_pkg::ST_PHASE_HI:fbcs_pkg::ST_PHASE_LO] = phase;
				next_rdata[fbcs_pkg::ST_PENDING_BIT] = sync_pending;
				next_rdata[fbcs_pkg::ST_LOCAL_BIT] = local_sync;
			end
			fbcs_pkg::REG_IRQ_STAT: begin
				next_rdata[fbcs_pkg::EV_W-1:0] = irq_stat;
			end
			fbcs_pkg::REG_IRQ_MASK: begin
				next_rdata[fbcs_pkg::EV_W-1:0] = irq_mask;
			end
			fbcs_pkg::REG_MODE: begin
				next_rdata[fbcs_pkg::MODE_SYNC_BIT] = mode_sync;
				next_rdata[fbcs_pkg::MODE_XFER_LO] = continuous_o;
				next_rdata[fbcs_pkg::MODE_SUBCOMMAND_ENABLE_BIT_BIT] = subcommand_enable_bit_o;
				next_rdata[fbcs_pkg::MODE_RSVD_LO] = mode_rsvd_bad;
				next_rdata[fbcs_pkg::MR_MULT_HI:fbcs_pkg::MR_MULT_LO] = cycle_multiplier;
			end
			default: begin
				next_rdata = fbcs_pkg::WORD_ZERO;
			end
		endcase
	end

	// Read data valid only the cycle after the strobe
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata_o <= fbcs_pkg::WORD_ZERO;
		end else if (reg_rd_i) begin
			reg_rdata_o <= next_rdata;
		end else begin
			reg_rdata_o <= fbcs_pkg::WORD_ZERO;
		end
	end
endmodule : fbcs_connect_sync
`default_nettype wire

// >>> shared/fbcs_pkg.sv
// Constants and types shared by the fieldbus connect and sync-phase block
package fbcs_pkg;
	// Command codes
	localparam logic [7:0] CMD_SYNC_SET = 8'h0D;
	localparam logic [7:0] CMD_CONNECT = 8'h0E;
	// Connection mode byte layout
	localparam int MODE_SUBCOMMAND_ENABLE_BIT_BIT = 7;
	localparam int MODE_RSVD_HI = 6;
	localparam int MODE_RSVD_LO = 4;
	localparam int MODE_XFER_HI = 3;
	localparam int MODE_XFER_LO = 2;
	localparam int MODE_SYNC_BIT = 1;
	localparam int MODE_RSVD0_BIT = 0;
	localparam logic [1:0] XFER_CONTINUOUS = 2'h1;
	localparam logic [1:0] XFER_NORMAL = 2'h0;
	// Cycle multiplier range
	localparam logic [7:0] MULT_MIN = 8'h01;
	localparam logic [7:0] MULT_MAX = 8'h20;
	// Register map, byte addresses
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_IRQ_STAT = 8'h08;
	localparam logic [7:0] REG_IRQ_MASK = 8'h0C;
	localparam logic [7:0] REG_MODE = 8'h10;
	// Control register fields
	localparam int CTRL_SYNC_MASK_BIT = 0;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	// Status register fields
	localparam int ST_PHASE_LO = 0;
	localparam int ST_PHASE_HI = 2;
	localparam int ST_PENDING_BIT = 3;
	localparam int ST_LOCAL_BIT = 4;
	// Event bits
	localparam int EV_W = 5;
	localparam int EV_WARN1 = 0;
	localparam int EV_PHASE3 = 1;
	localparam int EV_REJECT = 2;
	localparam int EV_LINK_ERR = 3;
	localparam int EV_DATA_WARN = 4;
	localparam logic [EV_W-1:0] EV_RESET = 5'h00;
	// Mode register fields
	localparam int MR_BYTE_LO = 0;
	localparam int MR_BYTE_HI = 7;
	localparam int MR_MULT_LO = 8;
	localparam int MR_MULT_HI = 15;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
	// Communication phases, one-hot
	typedef enum logic [2:0] {
		PHASE1 = 3'b001,
		PHASE2 = 3'b010,
		PHASE3 = 3'b100
	} fbcs_phase_e;
endpackage : fbcs_pkg

// >>> design/fbcs_mode_decode.sv
// Registered decoder for the connection mode byte
`timescale 1ns/1ps
`default_nettype none
module fbcs_mode_decode (
	// Clock and reset
	input wire logic clock_i,
	input wire logic rst_n_i,
	// Load
	input wire logic load_i,
	input wire logic [7:0] connection_mode_byte_i,
	// Decoded fields
	output logic sync_select_bit_o,
	output logic continuous_o,
	output logic subcommand_enable_bit_o,
	output logic reserved_bad_o
);
	logic [1:0] transfer_method_field;

	assign transfer_method_field = connection_mode_byte_i[fbcs_pkg::MODE_XFER_HI:fbcs_pkg::MODE_XFER_LO];

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sync_select_bit_o <= 1'b0;
			continuous_o <= 1'b0;
			subcommand_enable_bit_o <= 1'b0;
			reserved_bad_o <= 1'b0;
		end else if (load_i) begin
			sync_select_bit_o <= connection_mode_byte_i[fbcs_pkg::MODE_SYNC_BIT];
			// Codes 00 and 11 both mean single transfer
			continuous_o <= (transfer_method_field == fbcs_pkg::XFER_CONTINUOUS);
			subcommand_enable_bit_o <= connection_mode_byte_i[fbcs_pkg::MODE_SUBCOMMAND_ENABLE_BIT_BIT];
			// Flagged only; the far end owns these bits
			reserved_bad_o <= (|connection_mode_byte_i[fbcs_pkg::MODE_RSVD_HI:fbcs_pkg::MODE_RSVD_LO])
				| connection_mode_byte_i[fbcs_pkg::MODE_RSVD0_BIT];
		end
	end
endmodule : fbcs_mode_decode
`default_nettype wire

// >>> tb/fbcs_master.sv
// Network master model: command sender and transmission cycle edges
`timescale 1ns/1ps
`default_nettype none
module fbcs_master (
	// Clock and reset
	input wire logic clock_i,
	input wire logic arst_n_i,
	// Command lines
	output logic cmd_valid_o,
	output logic [7:0] cmd_code_o,
	output logic [7:0] mode_o,
	output logic [7:0] mult_o,
	// Transmission cycle edge
	output logic sync_edge_o
);
	// Lone slave on this link: far inside the station limit, no retry stations
	logic [2:0] tick;
	initial begin
		cmd_valid_o = 1'b0;
		cmd_code_o = 8'hA5;
		mode_o = 8'h5A;
		mult_o = 8'hC3;
	end
	// Communications cycle of eight transmission cycles
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			tick <= 3'h0;
		end else begin
			tick <= tick + 3'h1;
		end
	end
	assign sync_edge_o = tick == 3'h7;
	task automatic send(input logic [7:0] c, input logic [7:0] m, input logic [7:0] u);
		@(posedge clock_i);
		cmd_valid_o <= 1'b1;
		cmd_code_o <= c;
		mode_o <= m & 8'h8E;
		mult_o <= u;
		@(posedge clock_i);
		cmd_valid_o <= 1'b0;
		// Idle lines carry garbage, never the last value
		cmd_code_o <= ~c;
		mode_o <= ~m;
		mult_o <= ~u;
	endtask : send
endmodule : fbcs_master
`default_nettype wire

// >>> tb/fbcs_connect_sync_asserts.sv
// Port checker of the connect and sync-phase block
`timescale 1ns/1ps
`default_nettype none
module fbcs_connect_sync_asserts (
	// Clock and reset
	input wire logic clock_i,
	input wire logic arst_n_i,
	// Command side
	input wire logic cmd_valid_i,
	input wire logic [7:0] cmd_code_i,
	input wire logic [7:0] connection_mode_byte_i,
	input wire logic [7:0] cycle_multiplier_i,
	input wire logic link_error_i,
	// Watched outputs
	input wire logic rsp_valid_o,
	input wire logic [7:0] rsp_code_o,
	input wire logic [2:0] phase_o,
	input wire logic sync_select_bit_o,
	input wire logic continuous_o,
	input wire logic subcommand_enable_bit_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!arst_n_i);
	logic ok_mult;
	assign ok_mult = cycle_multiplier_i >= 8'h01 && cycle_multiplier_i <= 8'h20;
	sequence s_conn;
		cmd_valid_i && cmd_code_i == 8'h0E && phase_o == 3'b001 && ok_mult;
	endsequence
	sequence s_sync;
		cmd_valid_i && cmd_code_i == 8'h0D && phase_o == 3'b010;
	endsequence
	rsp_one_a: assert property (cmd_valid_i |=> rsp_valid_o)
		else $error("missing response");
	rsp_only_a: assert property (!cmd_valid_i |=> !rsp_valid_o)
		else $error("spurious response");
	conn_sync_a: assert property (s_conn ##0 connection_mode_byte_i[1] |=> phase_o == 3'b100)
		else $error("sync connect missed phase 3");
	conn_async_a: assert property (s_conn ##0 !connection_mode_byte_i[1] |=>
		phase_o == 3'b010 && rsp_code_o == 8'h0E) else $error("async connect wrong");
	mode_sync_a: assert property (s_conn |=> sync_select_bit_o == $past(connection_mode_byte_i[1]))
		else $error("sync select wrong");
	mode_xfer_a: assert property (s_conn |=>
		continuous_o == ($past(connection_mode_byte_i[3:2]) == 2'b01)) else $error("transfer wrong");
	mode_sub_a: assert property (s_conn |=> subcommand_enable_bit_o == $past(connection_mode_byte_i[7]))
		else $error("subcommand bit wrong");
	refuse_nop_a: assert property (cmd_valid_i && phase_o == 3'b001 &&
		!(cmd_code_i inside {8'h0E, 8'h0F, 8'h00}) |=> rsp_code_o == 8'h00) else $error("no NOP reply");
	sync_echo_a: assert property (s_sync |=> rsp_valid_o && rsp_code_o == 8'h0D)
		else $error("start-sync not echoed");
	link_drop_a: assert property (phase_o == 3'b100 && link_error_i && !cmd_valid_i |=>
		phase_o == 3'b010) else $error("link error kept phase 3");
endmodule : fbcs_connect_sync_asserts
bind fbcs_connect_sync fbcs_connect_sync_asserts fbcs_connect_sync_asserts_i (.*);
`default_nettype wire

// >>> tb/fbcs_connect_sync_tb.sv
// Self-checking bench of the connect and sync-phase block
`timescale 1ns/1ps
`default_nettype none
module fbcs_connect_sync_tb;
	logic clock_i, arst_n_i, link_error_i, local_tool_i, reg_wr_i, reg_rd_i;
	logic [7:0] reg_addr_i;
	logic [31:0] reg_wdata_i, reg_rdata_o;
	logic cmd_valid_i, sync_edge_i, rsp_valid_o, irq_o;
	logic [7:0] cmd_code_i, connection_mode_byte_i, cycle_multiplier_i, rsp_code_o;
	logic [2:0] phase_o;
	logic sync_select_bit_o, continuous_o, subcommand_enable_bit_o;
	int n_errors = 0;
	int num_checks = 0;
	int cycles = 0;
	logic [7:0] modes [4] = '{8'h02, 8'h86, 8'h8E, 8'h0C};
	logic [7:0] bad_m [2] = '{8'h00, 8'h21};
	logic [7:0] zero_a [5] = '{8'h00, 8'h08, 8'h0C, 8'h10, 8'h40};
	fbcs_master fbcs_master_i (.clock_i, .arst_n_i, .cmd_valid_o(cmd_valid_i), .cmd_code_o(cmd_code_i),
		.mode_o(connection_mode_byte_i), .mult_o(cycle_multiplier_i), .sync_edge_o(sync_edge_i));
	fbcs_connect_sync fbcs_connect_sync_i (.clock_i, .arst_n_i, .cmd_valid_i, .cmd_code_i,
		.connection_mode_byte_i, .cycle_multiplier_i, .sync_edge_i, .link_error_i, .local_tool_i,
		.rsp_valid_o, .rsp_code_o, .phase_o, .sync_select_bit_o, .continuous_o, .subcommand_enable_bit_o,
		.reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .irq_o);
	////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock_i);
		reg_wr_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge clock_i);
		reg_wr_i <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clock_i);
		reg_rd_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge clock_i);
		reg_rd_i <= 1'b0;
		#1;
		chk("reg_rdata_o", exp, reg_rdata_o);
	endtask : rd
	// Code FF or phase 000 skip that comparison
	task automatic cmd(input logic [7:0] c, m, u, er, input logic [2:0] ep);
		fbcs_master_i.send(c, m, u);
		#1;
		chk("rsp_valid_o", 1, rsp_valid_o);
		if (er !== 8'hFF) chk("rsp_code_o", er, rsp_code_o);
		if (ep !== 3'b000) chk("phase_o", ep, phase_o);
	endtask : cmd
	task automatic wait_edges(input int n);
		repeat (n) @(posedge clock_i);
		#1;
	endtask : wait_edges
	task automatic finish_test();
		$display("Checks %0d mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : finish_test
	////////////////////////////////
	initial begin
		clock_i = 1'b0;
		forever #10 clock_i = ~clock_i;
	end
	always @(posedge clock_i) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			n_errors++;
			finish_test();
		end
	end
	initial begin
		arst_n_i = 1'b0;
		link_error_i = 1'b0;
		local_tool_i = 1'b0;
		reg_addr_i = 8'h00;
		reg_wdata_i = 32'h0;
		reg_wr_i = 1'b0;
		reg_rd_i = 1'b0;
		repeat (8) @(posedge clock_i);
		arst_n_i <= 1'b1;
		wait_edges(2);
		chk("phase_o", 3'b001, phase_o);
		wr(8'h40, 32'hFFFF_FFFF);
		rd(8'h04, 32'h1);
		foreach (zero_a[i]) rd(zero_a[i], 32'h0);
		$display("Test reset done");
		cmd(8'h03, 8'h00, 8'h01, 8'h00, 3'b001);
		cmd(8'h0D, 8'h00, 8'h01, 8'h00, 3'b001);
		rd(8'h08, 32'h5);
		chk("irq_o", 0, irq_o);
		wr(8'h0C, 32'h4);
		wait_edges(2);
		chk("irq_o", 1, irq_o);
		wr(8'h08, 32'h4);
		rd(8'h08, 32'h1);
		chk("irq_o", 0, irq_o);
		wr(8'h08, 32'h1F);
		cmd(8'h00, 8'h00, 8'h01, 8'h00, 3'b001);
		cmd(8'h0F, 8'h00, 8'h01, 8'h0F, 3'b001);
		rd(8'h08, 32'h0);
		$display("Test refusal done");
		foreach (bad_m[i]) cmd(8'h0E, 8'h02, bad_m[i], 8'hFF, 3'b001);
		rd(8'h08, 32'h10);
		wr(8'h08, 32'h1F);
		$display("Test multiplier done");
		cmd(8'h0E, 8'h00, 8'h20, 8'h0E, 3'b010);
		chk("sync_select_bit_o", 0, sync_select_bit_o);
		cmd(8'h0E, 8'h02, 8'h01, 8'h0E, 3'b010);
		rd(8'h10, 32'h2000);
		wait_edges(20);
		chk("phase_o", 3'b010, phase_o);
		cmd(8'h0D, 8'h00, 8'h01, 8'h0D, 3'b000);
		wait_edges(10);
		chk("phase_o", 3'b100, phase_o);
		$display("Test start-sync done");
		@(posedge clock_i);
		link_error_i <= 1'b1;
		@(posedge clock_i);
		link_error_i <= 1'b0;
		#1;
		chk("phase_o", 3'b010, phase_o);
		rd(8'h08, 32'hA);
		wr(8'h08, 32'h1F);
		local_tool_i <= 1'b1;
		wait_edges(4);
		cmd(8'h0D, 8'h00, 8'h01, 8'h0D, 3'b010);
		wait_edges(10);
		chk("phase_o", 3'b010, phase_o);
		rd(8'h08, 32'h1);
		local_tool_i <= 1'b0;
		wait_edges(4);
		wr(8'h00, 32'h1);
		cmd(8'h0D, 8'h00, 8'h01, 8'h0D, 3'b100);
		cmd(8'h0D, 8'h00, 8'h01, 8'h0D, 3'b100);
		wr(8'h00, 32'h0);
		$display("Test restart done");
		foreach (modes[i]) begin
			cmd(8'h0F, 8'h00, 8'h01, 8'h0F, 3'b001);
			cmd(8'h0E, modes[i], 8'h01, 8'h0E, modes[i][1] ? 3'b100 : 3'b010);
			chk("sync_select_bit_o", modes[i][1], sync_select_bit_o);
			chk("continuous_o", modes[i][3:2] == 2'b01, continuous_o);
			chk("subcommand_enable_bit_o", modes[i][7], subcommand_enable_bit_o);
		end
		$display("Test modes done");
		@(posedge clock_i);
		arst_n_i <= 1'b0;
		#1;
		chk("phase_o", 3'b001, phase_o);
		chk("irq_o", 0, irq_o);
		$display("Test second reset done");
		finish_test();
	end
endmodule : fbcs_connect_sync_tb
`default_nettype wire
